// [src/gst_pkg.sv]
// gated sixteen-bit timer: register map, fields, resets and types
// Function
// R1 - single pulse needs go bit, arms on edge
// R2 - trailing edge clears go, further gates ignored
// R3 - clearing single pulse enable clears go
// R4 - toggle plus single pulse counts full period
// R5 - gate level readable at bit 2 always
// R6 - gate level falling edge sets gate flag
// R7 - count wraps FFFF to 0000, sets overflow
// R8 - overflow irq needs on and all enables
// R9 - sleep counting only unsynchronised external source
// R10 - secondary oscillator source unaffected by sleep; the code stops every outside source in sleep unless the sync bit is set
// R11 - capture event copies count to capture
// R12 - compare match of count raises event
// R13 - conversion trigger clears count, write wins
// R14 - software should run synchronous with trigger
// R15 - prescale field bits 5-4 divides 1..8
// R16 - sync bit ignored for system clocks
// R17 - wide access bit 1 selects 16-bit
// R18 - on bit 0 runs timer, clears flop
// R19 - gate enable bit 7 makes gate control
// R20 - gate polarity bit 6 selects active level
// R21 - toggle bit 5 toggles flop, else clear
// R22 - four-bit clock select picks source
// R23 - count write clears hidden prescaler
// R24 - five-bit gate select picks gate input
// R25 - wide mode latches high, buffers high write
package gst_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_TCTL = 8'h00;
    localparam logic [7:0] OFF_GCTL = 8'h04;
    localparam logic [7:0] OFF_CSEL = 8'h08;
    localparam logic [7:0] OFF_GSEL = 8'h0C;
    localparam logic [7:0] OFF_CNTL = 8'h10;
    localparam logic [7:0] OFF_CNTH = 8'h14;
    localparam logic [7:0] OFF_FLAG = 8'h18;
    localparam logic [7:0] OFF_IREN = 8'h1C;
    localparam logic [7:0] OFF_CMPV = 8'h20;
    localparam logic [7:0] OFF_CMPC = 8'h24;
    localparam logic [7:0] OFF_CAPV = 8'h28;
    // timer_control fields
    localparam int TC_ON = 0;
    localparam int TC_WIDE = 1;
    localparam int TC_SYNC = 2;
    localparam int TC_PS_LO = 4;
    // gate_control fields
    localparam int GC_VAL = 2;
    localparam int GC_GO = 3;
    localparam int GC_SPM = 4;
    localparam int GC_GTM = 5;
    localparam int GC_POL = 6;
    localparam int GC_GE = 7;
    // flag / enable fields
    localparam int FL_OVF = 0;
    localparam int FL_GATE = 1;
    localparam int IE_PERIPHERAL_IRQ_ENABLE = 2;
    localparam int IE_GIE = 3;
    // compare control fields
    localparam int CC_EN = 0;
    localparam int CC_TRIG = 1;
    // clock select codes
    localparam logic [3:0] CS_FOSC4 = 4'h1;
    localparam logic [3:0] CS_FOSC = 4'h2;
    localparam logic [3:0] CS_LAST = 4'hD;
    localparam logic [4:0] GS_LAST = 5'h10;
    localparam int N_CLK_SRC = 14;
    localparam int N_GATE_SRC = 17;
    localparam logic [1:0] FOSC4_DIV_LAST = 2'h3;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;

    typedef struct packed {
        logic [1:0] ps;
        logic sync;
        logic wide;
        logic on;
    } gst_tctl_t;

    typedef struct packed {
        logic ge;
        logic pol;
        logic gate_toggle_enable;
        logic spm;
        logic go;
    } gst_gctl_t;

    typedef enum logic [2:0] {
        SP_IDLE = 3'b001,
        SP_ARMED = 3'b010,
        SP_BUSY = 3'b100
    } gst_sp_t;
endpackage : gst_pkg

// [src/gst_edge.sv]
// gst_edge: optional two-stage synchroniser with edge pulses
`timescale 1ns/100ps
module gst_edge (
    input wire logic clk, // system clock
    input wire logic rst_n, // synchronised reset, active low
    input wire logic d, // raw level
    input wire logic bypass, // 1 takes the level without synchroniser
    output logic lvl, // level in use
    output logic rise, // one-cycle pulse on rising edge
    output logic fall // one-cycle pulse on falling edge
);
    logic s1_r;
    logic s2_r;
    logic prev_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            prev_r <= lvl;
        end
    end

    // switching bypass can skip or add one edge, as in the real part
    assign lvl = bypass ? d : s2_r;
    assign rise = lvl & ~prev_r;
    assign fall = ~lvl & prev_r;
endmodule : gst_edge

// [src/gst_timer.sv]
// gst_timer: gated sixteen-bit timer with APB register access
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module gst_timer (
    input wire logic CLK, // 40 MHz system clock
    input wire logic RST_N, // asynchronous reset, active low
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB access phase
    input wire logic PWRITE, // APB direction, 1 write
    input wire logic [gst_pkg::ADDR_W-1:0] PADDR, // APB byte address
    input wire logic [31:0] PWDATA, // APB write data
    output logic [31:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // APB error, unmapped address
    input wire logic [gst_pkg::N_CLK_SRC-1:0] CLK_SRC, // clock sources
    input wire logic [gst_pkg::N_GATE_SRC-1:0] GATE_SRC, // gate sources
    input wire logic SLEEP, // device in sleep
    input wire logic CAPT_EVT, // capture event pulse
    output logic [15:0] COUNT, // time base for capture/compare
    output logic OVF_IRQ, // overflow interrupt request
    output logic GATE_IRQ, // gate event interrupt request
    output logic WAKE, // wake request from sleep
    output logic CMP_EVENT, // compare match pulse
    output logic CONV_TRIG // conversion trigger pulse
);
    import gst_pkg::*;

    function automatic logic is_sys_clk(input logic [3:0] cs);
        is_sys_clk = (cs == CS_FOSC) || (cs == CS_FOSC4);
    endfunction : is_sys_clk

    // reset release
    logic rs1_r;
    logic rst_n;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rs1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rst_n <= rs1_r;
        end
    end

    // registers
    gst_tctl_t tctl_r;
    gst_gctl_t gctl_r;
    logic [3:0] csel_r;
    logic [4:0] gsel_r;
    logic [1:0] flag_r;
    logic [3:0] iren_r;
    logic [15:0] cmpv_r;
    logic [1:0] cmpc_r;
    logic [15:0] capv_r;
    logic [15:0] cnt_r;
    logic [7:0] hold_r;
    logic [2:0] psc_r;
    logic [1:0] div4_r;
    gst_sp_t sp_r;
    gst_sp_t sp_nxt;
    logic tff_r;
    logic gtm_d_r;
    logic gate_level_status_d_r;
    logic match_d_r;

    // bus decode
    wire setup = PSEL & ~PENABLE;
    wire acc = PSEL & PENABLE & PREADY;
    wire wr = acc & PWRITE;
    wire rd = setup & ~PWRITE; // same edge that captures PRDATA
    wire a_tctl = PADDR == OFF_TCTL;
    wire a_gctl = PADDR == OFF_GCTL;
    wire a_csel = PADDR == OFF_CSEL;
    wire a_gsel = PADDR == OFF_GSEL;
    wire a_cntl = PADDR == OFF_CNTL;
    wire a_cnth = PADDR == OFF_CNTH;
    wire a_flag = PADDR == OFF_FLAG;
    wire a_iren = PADDR == OFF_IREN;
    wire a_cmpv = PADDR == OFF_CMPV;
    wire a_cmpc = PADDR == OFF_CMPC;
    wire a_capv = PADDR == OFF_CAPV;
    wire mapped = a_tctl | a_gctl | a_csel | a_gsel | a_cntl | a_cnth
        | a_flag | a_iren | a_cmpv | a_cmpc | a_capv;
    wire wr_lo = wr & a_cntl;
    wire wr_hi = wr & a_cnth;
    wire wr_lo_now = wr_lo;
    // in wide mode the high byte waits in the holding register
    wire wr_hi_now = wr_hi & ~tctl_r.wide; // R25
    wire cnt_wr = wr_lo | wr_hi; // R23

    // clock source path
    wire cs_valid = csel_r <= CS_LAST; // R22
    wire cs_raw = cs_valid ? CLK_SRC[csel_r] : 1'b0; // R22
    wire sys_clk = is_sys_clk(csel_r);
    // sync bit matters only for non-system sources
    wire bypass = ~sys_clk & tctl_r.sync; // R16
    wire src_rise;
    gst_edge u_clk_edge (
        .clk(CLK),
        .rst_n(rst_n),
        .d(cs_raw),
        .bypass(bypass),
        .lvl(),
        .rise(src_rise),
        .fall()
    );
    wire tick_src = (csel_r == CS_FOSC) ? 1'b1 :
        (csel_r == CS_FOSC4) ? (div4_r == FOSC4_DIV_LAST) : src_rise;
    // only an unsynchronised outside source keeps counting in sleep
    wire sleep_ok = bypass & ~is_sys_clk(csel_r); // R9 R10
    wire src_run = tctl_r.on & (~SLEEP | sleep_ok); // R9 R18
    wire [2:0] psc_last = 3'((1 << tctl_r.ps) - 1); // R15
    wire psc_tick = src_run & tick_src & (psc_r == psc_last); // R15

    // gate path
    wire gs_valid = gsel_r <= GS_LAST; // R24
    wire gs_raw = gs_valid ? GATE_SRC[gsel_r] : 1'b0; // R24
    wire g_lvl;
    gst_edge u_gate_edge (
        .clk(CLK),
        .rst_n(rst_n),
        .d(gs_raw),
        .bypass(1'b0),
        .lvl(g_lvl),
        .rise(),
        .fall()
    );
    wire g_act = gctl_r.pol ? g_lvl : ~g_lvl; // R20
    logic g_act_d_r;
    wire g_act_rise = g_act & ~g_act_d_r;
    wire tff_nxt = (~gctl_r.gate_toggle_enable | ~tctl_r.on) ? 1'b0 : // R18 R21
        (g_act_rise ? ~tff_r : tff_r); // R21
    wire g_tm = gctl_r.gate_toggle_enable ? tff_r : g_act; // R4 R21
    wire g_tm_rise = g_tm & ~gtm_d_r;
    wire g_tm_fall = ~g_tm & gtm_d_r;
    wire sp_done = (sp_r == SP_BUSY) & g_tm_fall; // R2
    // gate level as seen by the counter, valid even with the gate off
    wire gate_level_status = gctl_r.spm ? (g_tm & (sp_r == SP_BUSY)) : g_tm; // R5
    wire gate_level_status_fall = gate_level_status_d_r & ~gate_level_status; // R6
    wire gate_open = ~gctl_r.ge | gate_level_status; // R19
    wire inc = psc_tick & gate_open; // R19

    // single pulse sequencer
    always_comb begin
        sp_nxt = sp_r;
        case (sp_r)
            SP_IDLE: begin
                if (gctl_r.spm & gctl_r.go) begin
                    sp_nxt = SP_ARMED; // R1
                end
            end
            SP_ARMED: begin
                if (~gctl_r.spm | ~gctl_r.go) begin
                    sp_nxt = SP_IDLE; // R3
                end else if (g_tm_rise) begin
                    sp_nxt = SP_BUSY; // R1
                end
            end
            SP_BUSY: begin
                if (~gctl_r.spm | g_tm_fall) begin
                    sp_nxt = SP_IDLE; // R2
                end
            end
            default: sp_nxt = SP_IDLE;
        endcase
    end

    // compare
    wire match = cmpc_r[CC_EN] & (cnt_r == cmpv_r); // R12
    wire cmp_pulse = match & ~match_d_r; // R12
    wire trig = cmp_pulse & cmpc_r[CC_TRIG]; // R13

    // counter next value: write, then trigger clear, then increment
    wire wrap = inc & (cnt_r == CNT_MAX); // R7
    logic [15:0] cnt_nxt;
    always_comb begin
        cnt_nxt = cnt_r;
        if (wr_lo_now & tctl_r.wide) begin
            cnt_nxt = {hold_r, PWDATA[7:0]}; // R17 R25
        end else if (wr_lo_now | wr_hi_now) begin
            if (wr_lo_now) begin
                cnt_nxt[7:0] = PWDATA[7:0]; // R17
            end else begin
                cnt_nxt[15:8] = PWDATA[7:0]; // R17
            end
        end else if (trig) begin
            cnt_nxt = CNT_ZERO; // R13
        end else if (inc) begin
            cnt_nxt = 16'(cnt_r + 16'h0001); // R7
        end
    end
    wire ovf_set = wrap & ~cnt_wr & ~trig; // R7 R13

    // read mux
    wire [7:0] tctl_rd = {2'b00, tctl_r.ps, 1'b0, tctl_r.sync,
        tctl_r.wide, tctl_r.on};
    wire [7:0] gctl_rd = {gctl_r.ge, gctl_r.pol, gctl_r.gate_toggle_enable,
        gctl_r.spm, gctl_r.go, gate_level_status, 2'b00}; // R5
    wire [7:0] cnth_rd = tctl_r.wide ? hold_r : cnt_r[15:8]; // R25
    wire [31:0] rd_mux =
        a_tctl ? {24'h00_0000, tctl_rd} :
        a_gctl ? {24'h00_0000, gctl_rd} :
        a_csel ? {28'h000_0000, csel_r} :
        a_gsel ? {27'h000_0000, gsel_r} :
        a_cntl ? {24'h00_0000, cnt_r[7:0]} :
        a_cnth ? {24'h00_0000, cnth_rd} :
        a_flag ? {30'h0000_0000, flag_r} :
        a_iren ? {28'h000_0000, iren_r} :
        a_cmpv ? {16'h0000, cmpv_r} :
        a_cmpc ? {30'h0000_0000, cmpc_r} :
        a_capv ? {16'h0000, capv_r} : 32'h0000_0000;

    // flags: hardware set wins over software clear
    wire [1:0] flag_clr = (wr & a_flag) ? PWDATA[1:0] : 2'b00;
    wire [1:0] flag_set = {gate_level_status_fall, ovf_set}; // R6 R7
    wire [1:0] flag_nxt = (flag_r & ~flag_clr) | flag_set; // R8

    // bus slave, no wait states
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= setup;
            PSLVERR <= setup & ~mapped;
            PRDATA <= setup ? rd_mux : 32'h0000_0000;
        end
    end

    // control registers
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            tctl_r <= gst_tctl_t'(REG_RST[4:0]);
            csel_r <= REG_RST[3:0];
            gsel_r <= REG_RST[4:0];
            iren_r <= REG_RST[3:0];
            cmpv_r <= WORD_RST;
            cmpc_r <= REG_RST[1:0];
        end else if (wr) begin
            if (a_tctl) begin
                tctl_r <= gst_tctl_t'({PWDATA[5:4], PWDATA[2:0]});
            end
            if (a_csel) begin
                csel_r <= PWDATA[3:0];
            end
            if (a_gsel) begin
                gsel_r <= PWDATA[4:0];
            end
            if (a_iren) begin
                iren_r <= PWDATA[3:0];
            end
            if (a_cmpv) begin
                cmpv_r <= PWDATA[15:0];
            end
            if (a_cmpc) begin
                cmpc_r <= PWDATA[1:0];
            end
        end
    end

    // gate control; go is cleared by hardware
    wire spm_wr = wr & a_gctl;
    wire spm_nxt = spm_wr ? PWDATA[GC_SPM] : gctl_r.spm;
    wire go_wr = spm_wr ? PWDATA[GC_GO] : gctl_r.go;
    wire go_nxt = go_wr & spm_nxt & ~sp_done; // R2 R3
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            gctl_r <= gst_gctl_t'(REG_RST[4:0]);
        end else begin
            if (spm_wr) begin
                gctl_r.ge <= PWDATA[GC_GE];
                gctl_r.pol <= PWDATA[GC_POL];
                gctl_r.gate_toggle_enable <= PWDATA[GC_GTM];
            end
            gctl_r.spm <= spm_nxt;
            gctl_r.go <= go_nxt;
        end
    end

    // count, prescaler and holding byte
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= WORD_RST;
            hold_r <= REG_RST;
            psc_r <= 3'b000;
            div4_r <= 2'b00;
            capv_r <= WORD_RST;
        end else begin
            cnt_r <= cnt_nxt;
            div4_r <= 2'(div4_r + 2'b01);
            if (cnt_wr) begin
                psc_r <= 3'b000; // R23
            end else if (src_run & tick_src) begin
                psc_r <= (psc_r == psc_last) ? 3'b000 : 3'(psc_r + 3'b001);
            end
            if (rd & a_cntl & tctl_r.wide) begin
                hold_r <= cnt_r[15:8]; // R25
            end else if (wr_hi & tctl_r.wide) begin
                hold_r <= PWDATA[7:0]; // R25
            end
            if (CAPT_EVT) begin
                capv_r <= cnt_r; // R11
            end
        end
    end

    // gate state
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            sp_r <= SP_IDLE;
            tff_r <= 1'b0;
            gtm_d_r <= 1'b0;
            g_act_d_r <= 1'b0;
            gate_level_status_d_r <= 1'b0;
            match_d_r <= 1'b0;
            flag_r <= 2'b00;
        end else begin
            sp_r <= sp_nxt;
            tff_r <= tff_nxt;
            gtm_d_r <= g_tm;
            g_act_d_r <= g_act;
            gate_level_status_d_r <= gate_level_status;
            match_d_r <= match;
            flag_r <= flag_nxt;
        end
    end

    // outputs
    wire irq_path = iren_r[IE_PERIPHERAL_IRQ_ENABLE] & iren_r[IE_GIE];
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            COUNT <= WORD_RST;
            OVF_IRQ <= 1'b0;
            GATE_IRQ <= 1'b0;
            WAKE <= 1'b0;
            CMP_EVENT <= 1'b0;
            CONV_TRIG <= 1'b0;
        end else begin
            COUNT <= cnt_nxt;
            OVF_IRQ <= flag_r[FL_OVF] & iren_r[FL_OVF] & irq_path
                & tctl_r.on; // R8
            GATE_IRQ <= flag_r[FL_GATE] & iren_r[FL_GATE] & irq_path; // R6
            // wake needs no global enable; vectoring does
            WAKE <= SLEEP & flag_r[FL_OVF] & iren_r[FL_OVF]
                & iren_r[IE_PERIPHERAL_IRQ_ENABLE] & tctl_r.on; // R9
            CMP_EVENT <= cmp_pulse; // R12
            CONV_TRIG <= trig; // R13
        end
    end
endmodule : gst_timer

// [verification/gst_timer_sva.sv]
// concurrent checks on the timer's port behaviour
`timescale 1ns/100ps
module gst_timer_sva
    import gst_pkg::*;
(
    input wire logic CLK, // clock
    input wire logic RST_N, // reset
    input wire logic PSEL, // select
    input wire logic PENABLE, // access
    input wire logic PWRITE, // direction
    input wire logic [31:0] PRDATA, // read data
    input wire logic PREADY, // ready
    input wire logic PSLVERR, // error
    input wire logic SLEEP, // sleep
    input wire logic [15:0] COUNT, // count
    input wire logic WAKE, // wake
    input wire logic CMP_EVENT, // compare
    input wire logic CONV_TRIG // trigger
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    wire wr_now = PSEL && PWRITE;
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_answer;
        PSEL && PENABLE && PREADY;
    endsequence
    a_ready_next: assert property (s_setup |=> s_answer)
        else $error("no ready after setup");
    a_ready_single: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
        else $error("read data outside answer");
    a_err_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    a_count_step: assert property ($changed(COUNT) && !$past(wr_now)
        |-> COUNT == $past(COUNT) + 16'h0001 || COUNT == CNT_ZERO)
        else $error("count moved by other than one");
    a_count_wrap: assert property ($past(COUNT) == CNT_MAX
        && $changed(COUNT) && !$past(wr_now) |-> COUNT == CNT_ZERO)
        else $error("no wrap to zero");
    a_cmp_once: assert property (CMP_EVENT |=> !CMP_EVENT)
        else $error("compare pulse too long");
    a_trig_cmp: assert property (CONV_TRIG |-> CMP_EVENT)
        else $error("trigger without compare");
    a_trig_clear: assert property (CONV_TRIG && !wr_now
        |-> ##[0:2] COUNT == CNT_ZERO)
        else $error("trigger did not clear count");
    a_wake_sleep: assert property (WAKE |-> $past(SLEEP))
        else $error("wake while awake");
endmodule : gst_timer_sva
bind gst_timer gst_timer_sva u_sva (.CLK, .RST_N, .PSEL, .PENABLE,
    .PWRITE, .PRDATA, .PREADY, .PSLVERR, .SLEEP, .COUNT, .WAKE,
    .CMP_EVENT, .CONV_TRIG);

// [verification/gst_src_model.sv]
// clock, gate and capture sources around the timer
`timescale 1ns/100ps
module gst_src_model
    import gst_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic gate_lvl, // gate level asked by the bench
    input wire logic capt_req, // capture request
    output logic [N_CLK_SRC-1:0] clk_src, // clock levels
    output logic [N_GATE_SRC-1:0] gate_src, // gate levels
    output logic capt_evt // capture pulse
);
    logic [1:0] div_r;
    initial begin
        div_r = 2'h0;
        clk_src = '0;
        gate_src = '0;
        capt_evt = 1'b0;
    end
    // unused sources toggle every cycle so no stale level hides a fault
    always @(posedge clk) begin
        div_r <= div_r + 2'h1;
        clk_src <= {~clk_src[N_CLK_SRC-1:1], clk_src[0] ^ (div_r == 2'h3)};
        gate_src <= {~gate_src[N_GATE_SRC-1:1], gate_lvl};
        capt_evt <= capt_req;
    end
endmodule : gst_src_model

// [verification/tb_top.sv]
// self-checking bench for the gated timer
`timescale 1ns/100ps
module tb_top;
    import gst_pkg::*;
    logic CLK, RST_N, PSEL, PENABLE, PWRITE, SLEEP, gate_lvl, capt_req;
    logic PREADY, PSLVERR, err, OVF_IRQ, GATE_IRQ, WAKE, CAPT_EVT;
    logic CMP_EVENT, CONV_TRIG;
    logic [ADDR_W-1:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd, v;
    logic [N_CLK_SRC-1:0] CLK_SRC;
    logic [N_GATE_SRC-1:0] GATE_SRC;
    logic [15:0] COUNT, w16, prev;
    logic [7:0] rst_offs [4] = '{OFF_TCTL, OFF_CSEL, OFF_GSEL, OFF_IREN};
    int n_errors, samples_checked, cycles, n;
    gst_timer u_dut (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .CLK_SRC(CLK_SRC), .GATE_SRC(GATE_SRC),
        .SLEEP(SLEEP), .CAPT_EVT(CAPT_EVT), .COUNT(COUNT),
        .OVF_IRQ(OVF_IRQ), .GATE_IRQ(GATE_IRQ), .WAKE(WAKE),
        .CMP_EVENT(CMP_EVENT), .CONV_TRIG(CONV_TRIG));
    gst_src_model u_src (.clk(CLK), .gate_lvl(gate_lvl),
        .capt_req(capt_req), .clk_src(CLK_SRC), .gate_src(GATE_SRC),
        .capt_evt(CAPT_EVT));
    always #12.5 CLK = ~CLK;
    task automatic finish_test;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            finish_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // request held until ready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask : rd_chk
    initial begin
        {CLK, RST_N, PSEL, PENABLE, PWRITE, SLEEP, gate_lvl} = '0;
        capt_req = 1'b0;
        PADDR = '0;
        PWDATA = '0;
        v = $urandom(27591);
        repeat (8) @(posedge CLK);
        RST_N <= 1'b1;
        repeat (3) @(posedge CLK);
        foreach (rst_offs[i]) rd_chk("reset", rst_offs[i], 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, err);
        for (int i = 0; i < 4; i++) begin
            v = $urandom % 14;
            wr(OFF_CSEL, v);
            rd_chk("clk_sel", OFF_CSEL, v);
            v = $urandom % 17;
            wr(OFF_GSEL, v);
            rd_chk("gate_sel", OFF_GSEL, v);
        end
        wr(OFF_GSEL, 32'h0000_0000);
        wr(OFF_CSEL, 32'(CS_FOSC));
        wr(OFF_IREN, 32'h0000_000F);
        for (int p = 0; p < 4; p++) begin
            wr(OFF_TCTL, 32'h0000_0000);
            wr(OFF_FLAG, 32'h0000_0003);
            wr(OFF_CNTH, 32'h0000_00FF);
            wr(OFF_CNTL, 32'h0000_00F0);
            wr(OFF_TCTL, (32'(p) << TC_PS_LO) | 32'h0000_0001);
            repeat (16 * (1 << p) - 8) @(posedge CLK);
            rd_chk("ovf_early", OFF_FLAG, 32'h0000_0000);
            repeat (16) @(posedge CLK);
            rd_chk("ovf_set", OFF_FLAG, 32'h0000_0001);
            chk("ovf_irq", 32'h0000_0001, OVF_IRQ);
        end
        SLEEP <= 1'b1;
        repeat (2) @(posedge CLK);
        prev = COUNT;
        repeat (4) @(posedge CLK);
        chk("wake", 32'h0000_0001, WAKE);
        chk("sleep_hold", prev, COUNT);
        SLEEP <= 1'b0;
        wr(OFF_FLAG, 32'h0000_0003);
        rd_chk("ovf_clr", OFF_FLAG, 32'h0000_0000);
        wr(OFF_TCTL, 32'h0000_0002);
        w16 = $urandom;
        // let an increment launched by the stopping edge settle first
        @(posedge CLK);
        prev = COUNT;
        wr(OFF_CNTH, {24'h00_0000, w16[15:8]});
        @(posedge CLK);
        chk("hi_held", prev, COUNT);
        wr(OFF_CNTL, {24'h00_0000, w16[7:0]});
        @(posedge CLK);
        chk("wide_load", w16, COUNT);
        rd_chk("low_rd", OFF_CNTL, w16[7:0]);
        rd_chk("high_rd", OFF_CNTH, w16[15:8]);
        wr(OFF_TCTL, 32'h0000_0000);
        wr(OFF_CNTH, 32'h0000_0012);
        @(posedge CLK);
        chk("narrow_hi", {8'h12, w16[7:0]}, COUNT);
        capt_req <= 1'b1;
        @(posedge CLK);
        capt_req <= 1'b0;
        repeat (3) @(posedge CLK);
        rd_chk("capture", OFF_CAPV, {8'h12, w16[7:0]});
        wr(OFF_GCTL, 32'h0000_0040);
        gate_lvl <= 1'b1;
        repeat (6) @(posedge CLK);
        rd_chk("gate_hi", OFF_GCTL, 32'h0000_0044);
        wr(OFF_FLAG, 32'h0000_0003);
        gate_lvl <= 1'b0;
        repeat (6) @(posedge CLK);
        rd_chk("gate_lo", OFF_GCTL, 32'h0000_0040);
        rd_chk("gate_flag", OFF_FLAG, 32'h0000_0002);
        chk("gate_irq", 32'h0000_0001, GATE_IRQ);
        wr(OFF_TCTL, 32'h0000_0001);
        wr(OFF_GCTL, 32'h0000_00D8);
        rd_chk("go_set", OFF_GCTL, 32'h0000_00D8);
        for (int k = 0; k < 2; k++) begin
            prev = COUNT;
            gate_lvl <= 1'b1;
            repeat (6) @(posedge CLK);
            gate_lvl <= 1'b0;
            repeat (6) @(posedge CLK);
            chk("pulse_cnt", k == 0, COUNT != prev);
        end
        rd_chk("go_done", OFF_GCTL, 32'h0000_00D0);
        wr(OFF_GCTL, 32'h0000_00D8);
        wr(OFF_GCTL, 32'h0000_00C8);
        rd_chk("go_cleared", OFF_GCTL, 32'h0000_00C0);
        wr(OFF_GCTL, 32'h0000_00F8);
        prev = COUNT;
        repeat (3) begin
            gate_lvl <= 1'b1;
            repeat (6) @(posedge CLK);
            gate_lvl <= 1'b0;
            repeat (6) @(posedge CLK);
        end
        // toggle with single pulse counts one whole gate period only
        w16 = COUNT - prev;
        chk("toggle", 32'h0000_0001, w16 - 16'h0007 < 16'h0006);
        wr(OFF_GCTL, 32'h0000_0000);
        wr(OFF_TCTL, 32'h0000_0000);
        wr(OFF_CSEL, 32'h0000_0000);
        wr(OFF_CNTH, 32'h0000_00FF);
        wr(OFF_CNTL, 32'h0000_00FC);
        wr(OFF_FLAG, 32'h0000_0003);
        // unsynchronised outside source must keep counting while asleep
        wr(OFF_TCTL, 32'h0000_0005);
        SLEEP <= 1'b1;
        repeat (60) @(posedge CLK);
        chk("async_wake", 32'h0000_0001, WAKE);
        SLEEP <= 1'b0;
        wr(OFF_TCTL, 32'h0000_0000);
        wr(OFF_CSEL, 32'(CS_FOSC4));
        wr(OFF_FLAG, 32'h0000_0003);
        wr(OFF_CNTH, 32'h0000_0000);
        wr(OFF_CNTL, 32'h0000_0000);
        wr(OFF_CMPV, 32'h0000_0014);
        wr(OFF_CMPC, 32'h0000_0003);
        wr(OFF_TCTL, 32'h0000_0001);
        n = 0;
        while (CONV_TRIG !== 1'b1 && n < 200) begin
            @(posedge CLK);
            n++;
        end
        chk("trig_seen", 32'h0000_0001, CONV_TRIG);
        repeat (3) @(posedge CLK);
        chk("trig_clear", 32'h0000_0001, COUNT < 16'h0006);
        repeat (40) @(posedge CLK);
        rd_chk("no_ovf", OFF_FLAG, 32'h0000_0000);
        finish_test();
    end
endmodule : tb_top
